// file: design/sck_mem.sv
/*
 memory end: clock-enable driven state control of a two-bank sdram.
 assumes the controller runs on the same mclk, so pins are sampled directly.
*/
`timescale 1ns/100ps
`default_nettype none
module sck_mem (
    input wire logic mclk,
    input wire logic reset,
    sck_if.mem pins,
    output var sck_pkg::sck_state_t state,
    output logic suspended,
    output logic [1:0] bank_open,
    output logic [sck_pkg::ADDR_W-1:0] mode_reg,
    output logic illegal_cmd,
    output logic [sck_pkg::ROW_W-1:0] self_ref_row
);
    import sck_pkg::*;

    logic cke_now;
    logic cke_prev;
    logic [3:0] cmd;
    logic [ADDR_W-1:0] addr_q;
    logic [CNT_W-1:0] rc_cnt;
    logic [CNT_W-1:0] ref_cnt;
    logic [3:0] next_cmd;

    // quiet pins in a low-power mode are don't-care
    always_comb begin
        next_cmd = {pins.select_n, pins.row_n, pins.col_n, pins.write_n};
    end

    // pin capture on the rising edge, previous cke kept
    always_ff @(posedge mclk) begin
        if (reset) begin
            cke_now <= 1'b1;
            cke_prev <= 1'b1;
            cmd <= CMD_DESELECT;
            addr_q <= ADDR_ZERO;
        end else begin
            cke_prev <= cke_now;
            cke_now <= pins.cke;
            cmd <= next_cmd;
            addr_q <= pins.addr;
        end
    end

    // main state decision from the cke pair and the strobes
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= SCK_IDLE;
            suspended <= 1'b0;
            bank_open <= 2'h0;
            mode_reg <= ADDR_ZERO;
            illegal_cmd <= 1'b0;
            rc_cnt <= '0;
        end else begin
            illegal_cmd <= 1'b0;
            unique case (state)
                SCK_IDLE: begin
                    if (!cke_prev) begin
                        state <= SCK_POWER_DOWN;
                    end else if (!cke_now && cmd == CMD_REFRESH) begin
                        state <= SCK_SELF_REFRESH;
                    end else if (cke_now && !cmd[3]) begin
                        // activate/precharge, refresh and mode set decode
                        if (cmd == CMD_ACTIVATE) begin
                            bank_open[addr_q[BANK_SELECT_BIT]] <= 1'b1;
                            state <= SCK_ACTIVE;
                        end else if (cmd == CMD_MODE_SET) begin
                            mode_reg <= addr_q;
                        end
                        // precharge with both banks idle and refresh keep idle
                    end
                end
                SCK_SELF_REFRESH: begin
                    // cke low holds the mode; other pins are ignored
                    if (cke_now) begin
                        state <= SCK_SR_RECOVERY;
                        rc_cnt <= CNT_W'(ROW_CYCLE_CYC);
                        illegal_cmd <= !sck_is_quiet(cmd);
                    end
                end
                SCK_SR_RECOVERY: begin
                    if (suspended) begin
                        suspended <= !cke_now;
                    end else if (!cke_now) begin
                        // falling cke powers down whatever the command; a command that is not quiet is also flagged illegal
                        illegal_cmd <= !sck_is_quiet(cmd);
                        state <= SCK_POWER_DOWN;
                    end else begin
                        illegal_cmd <= !sck_is_quiet(cmd);
                        if (rc_cnt <= CNT_W'(1)) begin
                            state <= SCK_IDLE;
                        end else begin
                            rc_cnt <= rc_cnt - CNT_W'(1);
                        end
                    end
                end
                SCK_POWER_DOWN: begin
                    if (cke_now) begin
                        state <= SCK_IDLE;
                    end
                end
                SCK_ACTIVE: begin
                    if (!cke_now) begin
                        // operation frozen while suspended; tables for banks left out
                        suspended <= 1'b1;
                    end else begin
                        suspended <= 1'b0;
                        if (!suspended && cmd == CMD_PRECHARGE) begin
                            if (addr_q[PRECHARGE_ALL_BIT]) begin
                                bank_open <= 2'h0;
                                state <= SCK_IDLE;
                            end else begin
                                bank_open[addr_q[BANK_SELECT_BIT]] <= 1'b0;
                                if (bank_open == (2'h1 << addr_q[BANK_SELECT_BIT])) begin
                                    state <= SCK_IDLE;
                                end
                            end
                        end else if (!suspended && cmd == CMD_ACTIVATE) begin
                            bank_open[addr_q[BANK_SELECT_BIT]] <= 1'b1;
                        end
                    end
                end
                default: state <= SCK_IDLE;
            endcase
        end
    end

    // internal refresh timer; walks rows without controller commands
    always_ff @(posedge mclk) begin
        if (reset) begin
            ref_cnt <= '0;
            self_ref_row <= '0;
        end else if (state == SCK_SELF_REFRESH) begin
            if (ref_cnt == CNT_W'(SELF_REF_CYC - 1)) begin
                ref_cnt <= '0;
                self_ref_row <= self_ref_row + ROW_W'(1);
            end else begin
                ref_cnt <= ref_cnt + CNT_W'(1);
            end
        end else begin
            ref_cnt <= '0;
        end
    end
endmodule // sck_mem
`default_nettype wire

// file: design/sck_pkg.sv
/*
 package for the clock-enable state control of a two-bank sdram:
 command encodings, state enumeration and timing counts.
 assumes a single 125 MHz clock shared by controller and memory model.
*/
package sck_pkg;
    localparam int unsigned CLK_PERIOD_PS = 8000;
    // row cycle time and wake setup, figures in picoseconds
    localparam int unsigned ROW_CYCLE_PS = 80000;
    localparam int unsigned WAKE_SETUP_PS = 8000;
    localparam int unsigned ROW_CYCLE_CYC = (ROW_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WAKE_SETUP_CYC = (WAKE_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // internal refresh interval while self-refreshing (64 ms / 4096 rows = 15.625 us)
    localparam int unsigned SELF_REF_NS = 15625;
    localparam int unsigned SELF_REF_CYC = (SELF_REF_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned CNT_W = 12;
    localparam int unsigned ROW_W = 11;
    localparam int unsigned BANK_SELECT_BIT = 11;
    localparam int unsigned PRECHARGE_ALL_BIT = 10;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;
    // strobe order {select_n, row_n, col_n, write_n}
    localparam logic [3:0] CMD_DESELECT = 4'hf;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_MODE_SET = 4'h0;

    typedef enum logic [2:0] {
        SCK_IDLE,
        SCK_SELF_REFRESH,
        SCK_SR_RECOVERY,
        SCK_POWER_DOWN,
        SCK_ACTIVE
    } sck_state_t;

    typedef enum logic [2:0] {
        SCK_REQ_NONE,
        SCK_REQ_ACTIVATE,
        SCK_REQ_PRECHARGE,
        SCK_REQ_REFRESH,
        SCK_REQ_MODE_SET,
        SCK_REQ_SELF_REFRESH,
        SCK_REQ_POWER_DOWN,
        SCK_REQ_SUSPEND
    } sck_req_t;

    // deselect or no-operation: the only commands legal on wake
    function automatic logic sck_is_quiet(input logic [3:0] cmd);
        return cmd[3] || (cmd[2] && cmd[1]);
    endfunction
endpackage

// file: design/sck_if.sv
/*
 interface joining the sdram controller end and the memory end.
 assumes both ends run on the same mclk; no two-way pins are modelled.
*/
`timescale 1ns/100ps
`default_nettype none
interface sck_if;
    logic cke;
    logic select_n;
    logic row_n;
    logic col_n;
    logic write_n;
    logic [11:0] addr;

    modport ctrl (
        output cke,
        output select_n,
        output row_n,
        output col_n,
        output write_n,
        output addr
    );
    modport mem (
        input cke,
        input select_n,
        input row_n,
        input col_n,
        input write_n,
        input addr
    );
endinterface
`default_nettype wire

// file: design/sck_sync3.sv
/*
 three-stage input capture; a change is accepted once stages two and three agree.
 assumes the input may come from outside mclk's domain.
*/
`timescale 1ns/100ps
`default_nettype none
module sck_sync3 #(
    parameter int unsigned W = 1
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (reset) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q <= s3;
            end
        end
    end
endmodule // sck_sync3
`default_nettype wire

// file: design/sck_ctrl.sv
/*
 controller end: drives cke and command pins on user request.
 assumes the memory end samples on the same mclk edge.
*/
`timescale 1ns/100ps
`default_nettype none
module sck_ctrl (
    input wire logic mclk,
    input wire logic reset,
    sck_if.ctrl pins,
    input wire sck_pkg::sck_req_t req,
    input wire logic [sck_pkg::ADDR_W-1:0] req_addr,
    input wire logic wake,
    output logic busy,
    output logic low_power
);
    import sck_pkg::*;

    typedef enum logic [1:0] {
        SCK_C_RUN,
        SCK_C_LOW,
        SCK_C_WAKE
    } sck_cstate_t;

    sck_cstate_t cst;
    logic was_self;
    logic [CNT_W-1:0] wait_cnt;
    logic [3:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic wake_q;

    // wake may come from outside the clock's domain; filtered before use
    sck_sync3 #(
        .W(1)
    ) sck_sync3_inst (
        .mclk(mclk),
        .reset(reset),
        .d(wake),
        .q(wake_q)
    );

    always_comb begin
        pins.select_n = cmd[3];
        pins.row_n = cmd[2];
        pins.col_n = cmd[1];
        pins.write_n = cmd[0];
        pins.addr = addr;
    end

    // request sequencing; refresh on self-refresh entry, quiet commands on power-down entry, exit and wait
    always_ff @(posedge mclk) begin
        if (reset) begin
            cst <= SCK_C_RUN;
            pins.cke <= 1'b1;
            cmd <= CMD_DESELECT;
            addr <= ADDR_ZERO;
            busy <= 1'b0;
            low_power <= 1'b0;
            was_self <= 1'b0;
            wait_cnt <= '0;
        end else begin
            cmd <= CMD_DESELECT;
            unique case (cst)
                SCK_C_RUN: begin
                    pins.cke <= 1'b1;
                    busy <= 1'b0;
                    unique case (req)
                        SCK_REQ_ACTIVATE: begin
                            cmd <= CMD_ACTIVATE;
                            addr <= req_addr;
                        end
                        SCK_REQ_PRECHARGE: begin
                            cmd <= CMD_PRECHARGE;
                            addr <= req_addr;
                        end
                        SCK_REQ_REFRESH: cmd <= CMD_REFRESH;
                        SCK_REQ_MODE_SET: begin
                            cmd <= CMD_MODE_SET;
                            addr <= req_addr;
                        end
                        SCK_REQ_SELF_REFRESH: begin
                            cmd <= CMD_REFRESH;
                            pins.cke <= 1'b0;
                            was_self <= 1'b1;
                            cst <= SCK_C_LOW;
                            busy <= 1'b1;
                            low_power <= 1'b1;
                        end
                        SCK_REQ_POWER_DOWN, SCK_REQ_SUSPEND: begin
                            cmd <= CMD_NOP;
                            pins.cke <= 1'b0;
                            was_self <= 1'b0;
                            cst <= SCK_C_LOW;
                            busy <= 1'b1;
                            low_power <= 1'b1;
                        end
                        SCK_REQ_NONE: cmd <= CMD_DESELECT;
                    endcase
                end
                SCK_C_LOW: begin
                    // cke stays low until wake
                    pins.cke <= 1'b0;
                    if (wake_q) begin
                        pins.cke <= 1'b1;
                        low_power <= 1'b0;
                        wait_cnt <= was_self ? CNT_W'(ROW_CYCLE_CYC + 2) : CNT_W'(WAKE_SETUP_CYC + 1);
                        cst <= SCK_C_WAKE;
                    end
                end
                SCK_C_WAKE: begin
                    cmd <= CMD_NOP;
                    if (wait_cnt <= CNT_W'(1)) begin
                        cst <= SCK_C_RUN;
                    end else begin
                        wait_cnt <= wait_cnt - CNT_W'(1);
                    end
                end
                default: cst <= SCK_C_RUN;
            endcase
        end
    end
endmodule // sck_ctrl
`default_nettype wire

// file: sim/sck_properties.sv
/*
 checker on the pins joining the sdram controller end to the memory end.
 assumes one mclk domain and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module sck_properties (
    input wire logic mclk,
    input wire logic reset,
    input wire logic cke,
    input wire logic select_n,
    input wire logic row_n,
    input wire logic col_n,
    input wire logic write_n,
    input wire logic [11:0] addr
);
    import sck_pkg::*;
    logic [3:0] cmd;
    logic quiet;
    logic [1:0] open;
    logic in_sr;
    logic [7:0] since;
    assign cmd = {select_n, row_n, col_n, write_n};
    assign quiet = select_n | (row_n & col_n); // deselect or no-operation
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // banks opened and closed as the pins show them
    always_ff @(posedge mclk) begin
        if (reset) begin
            open <= 2'h0;
        end else if (cke && cmd == CMD_ACTIVATE) begin
            open[addr[BANK_SELECT_BIT]] <= 1'b1;
        end else if (cke && cmd == CMD_PRECHARGE && addr[PRECHARGE_ALL_BIT]) begin
            open <= 2'h0;
        end else if (cke && cmd == CMD_PRECHARGE) begin
            open[addr[BANK_SELECT_BIT]] <= 1'b0;
        end
    end
    // self-refresh span, entered only by a refresh with cke falling
    always_ff @(posedge mclk) begin
        if (reset) begin
            in_sr <= 1'b0;
        end else if ($fell(cke) && cmd == CMD_REFRESH) begin
            in_sr <= 1'b1;
        end else if (cke) begin
            in_sr <= 1'b0;
        end
    end
    // cycles since self-refresh exit; saturates so it never wraps into a window
    always_ff @(posedge mclk) begin
        if (reset) begin
            since <= 8'hff;
        end else if (in_sr && cke) begin
            since <= 8'h00;
        end else if (since != 8'hff) begin
            since <= since + 8'h01;
        end
    end

    property p_sr_idle;
        $fell(cke) && cmd == CMD_REFRESH |-> open == 2'h0;
    endproperty
    a_sr_idle: assert property (p_sr_idle) else $error("self-refresh with bank open");
    property p_fall_legal;
        $fell(cke) |-> quiet || cmd == CMD_REFRESH;
    endproperty
    a_fall_legal: assert property (p_fall_legal) else $error("bad command at cke fall");
    property p_wake;
        $rose(cke) |-> quiet [*2];
    endproperty
    a_wake: assert property (p_wake) else $error("command inside wake setup");
    property p_recover;
        since < ROW_CYCLE_CYC |-> quiet;
    endproperty
    a_recover: assert property (p_recover) else $error("command in recovery");
    property p_mode_idle;
        cke && cmd == CMD_MODE_SET |-> open == 2'h0;
    endproperty
    a_mode_idle: assert property (p_mode_idle) else $error("mode set with bank open");
    property p_ref_idle;
        cke && $past(cke) && cmd == CMD_REFRESH |-> open == 2'h0;
    endproperty
    a_ref_idle: assert property (p_ref_idle) else $error("refresh with bank open");
    property p_act_free;
        cke && cmd == CMD_ACTIVATE |-> !open[addr[BANK_SELECT_BIT]];
    endproperty
    a_act_free: assert property (p_act_free) else $error("activate on open bank");
    property p_rst_pins;
        $fell(reset) |-> cke && select_n && addr == 12'h000;
    endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("pins not quiet after reset");

    c_sr: cover property ($fell(cke) && cmd == CMD_REFRESH);
    c_sr_exit: cover property (in_sr && cke);
    c_mode: cover property (cke && cmd == CMD_MODE_SET);
endmodule // sck_properties
`default_nettype wire

// file: sim/sck_bench.sv
/*
 bench: controller and memory ends face each other on one interface;
 a second memory end is driven directly, breaking rules on purpose.
 assumes the package timing counts and a 125 MHz mclk.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module sck_bench;
    import sck_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    sck_req_t req = SCK_REQ_NONE;
    logic [11:0] req_addr = 12'h000;
    logic wake = 1'b0;
    logic busy, low_power, suspended, suspended2, illegal_cmd, illegal_cmd2;
    sck_state_t state, state2;
    logic [1:0] bank_open, bank_open2;
    logic [11:0] mode_reg, mode_reg2;
    logic [10:0] self_ref_row, row2, row0;
    logic ill_seen = 1'b0;
    logic ill2_seen = 1'b0;
    int fail_count = 0;
    int cmp_count = 0;
    sck_if bus();
    sck_if bus2();

    sck_ctrl sck_ctrl_inst (.mclk(mclk), .reset(reset), .pins(bus), .req(req),
        .req_addr(req_addr), .wake(wake), .busy(busy), .low_power(low_power));
    sck_mem sck_mem_inst (.mclk(mclk), .reset(reset), .pins(bus), .state(state),
        .suspended(suspended), .bank_open(bank_open), .mode_reg(mode_reg),
        .illegal_cmd(illegal_cmd), .self_ref_row(self_ref_row));
    sck_mem sck_mem2_inst (.mclk(mclk), .reset(reset), .pins(bus2), .state(state2),
        .suspended(suspended2), .bank_open(bank_open2), .mode_reg(mode_reg2),
        .illegal_cmd(illegal_cmd2), .self_ref_row(row2));
    sck_properties sck_properties_inst (.mclk(mclk), .reset(reset), .cke(bus.cke),
        .select_n(bus.select_n), .row_n(bus.row_n), .col_n(bus.col_n),
        .write_n(bus.write_n), .addr(bus.addr));

    // clock
    initial begin
        forever #4 mclk = ~mclk;
    end
    // illegal pulses last one cycle, so keep them sticky
    always @(posedge mclk) begin
        if (illegal_cmd === 1'b1) ill_seen <= 1'b1;
        if (illegal_cmd2 === 1'b1) ill2_seen <= 1'b1;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // request held for exactly one sampling edge
    task automatic ask(input sck_req_t r, input logic [11:0] a);
        @(negedge mclk);
        req = r;
        req_addr = a;
        @(negedge mclk);
        req = SCK_REQ_NONE;
    endtask
    // wake passes four flops in the controller, so hold it four edges
    task automatic pulse_wake;
        @(negedge mclk);
        wake = 1'b1;
        repeat (4) @(negedge mclk);
        wake = 1'b0;
        @(negedge mclk);
    endtask
    // direct pin drive of the second memory end, held n edges
    task automatic drv(input logic k, input logic [3:0] c, input int n);
        @(negedge mclk);
        bus2.cke = k;
        {bus2.select_n, bus2.row_n, bus2.col_n, bus2.write_n} = c;
        repeat (n - 1) @(negedge mclk);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the roughly 2100 cycles the tests need
    initial begin
        #(8 * 20000);
        fail_count++;
        wrap_up;
    end

    initial begin
        bus2.cke = 1'b1;
        {bus2.select_n, bus2.row_n, bus2.col_n, bus2.write_n} = CMD_DESELECT;
        bus2.addr = 12'h5a5;
        cyc(4);
        reset = 1'b0;
        cyc(2);
        `CHK("state", SCK_IDLE, state)
        ask(SCK_REQ_MODE_SET, 12'h032);
        cyc(3);
        `CHK("mode_reg", 12'h032, mode_reg)
        ask(SCK_REQ_REFRESH, 12'h000);
        cyc(3);
        `CHK("state", SCK_IDLE, state)
        ask(SCK_REQ_ACTIVATE, 12'h800);
        cyc(3);
        `CHK("bank_open", 2'h2, bank_open)
        `CHK("state", SCK_ACTIVE, state)
        // suspend with a bank open, frozen until wake
        ask(SCK_REQ_SUSPEND, 12'h000);
        cyc(3);
        `CHK("suspended", 1'b1, suspended)
        cyc(5);
        `CHK("suspended", 1'b1, suspended)
        `CHK("bank_open", 2'h2, bank_open)
        pulse_wake;
        cyc(4);
        `CHK("suspended", 1'b0, suspended)
        ask(SCK_REQ_PRECHARGE, 12'h400);
        cyc(3);
        `CHK("bank_open", 2'h0, bank_open)
        // power-down from idle and back
        ask(SCK_REQ_POWER_DOWN, 12'h000);
        cyc(8);
        `CHK("state", SCK_POWER_DOWN, state)
        `CHK("busy", 1'b1, busy)
        `CHK("low_power", 1'b1, low_power)
        pulse_wake;
        cyc(5);
        `CHK("state", SCK_IDLE, state)
        // self-refresh, one internal refresh, then recovery
        ask(SCK_REQ_SELF_REFRESH, 12'h000);
        cyc(3);
        `CHK("state", SCK_SELF_REFRESH, state)
        row0 = self_ref_row;
        cyc(SELF_REF_CYC + 4);
        `CHK("self_ref_row", row0 + 11'h001, self_ref_row)
        pulse_wake;
        cyc(3);
        `CHK("state", SCK_SR_RECOVERY, state)
        cyc(ROW_CYCLE_CYC - 2);
        `CHK("state", SCK_SR_RECOVERY, state)
        cyc(1);
        `CHK("state", SCK_IDLE, state)
        `CHK("illegal_cmd", 1'b0, ill_seen)
        // second end: pins ignored in self-refresh, bad exit, power-down
        drv(1'b1, CMD_NOP, 2);
        drv(1'b0, CMD_REFRESH, 1);
        drv(1'b0, CMD_MODE_SET, 4);
        `CHK("state2", SCK_SELF_REFRESH, state2)
        `CHK("mode_reg2", 12'h000, mode_reg2)
        drv(1'b1, CMD_ACTIVATE, 1);
        drv(1'b1, CMD_NOP, 3);
        `CHK("illegal_cmd2", 1'b1, ill2_seen)
        `CHK("state2", SCK_SR_RECOVERY, state2)
        drv(1'b0, CMD_NOP, 3);
        `CHK("state2", SCK_POWER_DOWN, state2)
        drv(1'b1, CMD_NOP, 3);
        `CHK("state2", SCK_IDLE, state2)
        wrap_up;
    end
endmodule // sck_bench
`default_nettype wire
